// File: core/cpie_exec.sv
// Execution unit for idle, byte/word increment, return and jump.
// Assumes a program memory that answers prog_addr_o in the same cycle,
// a level interrupt request, and an AXI4-Lite master for the registers.
//
// Operation
// - Idle opcode stops the CPU clock enable
// - Interrupt request or reset ends idle
// - Byte increment, three forms, four cycles
// - Increments set Z, S, V; others kept
// - Word increment on even pair, eight cycles
// - Even register is high byte, carry propagates
// - Normal return pops flags then PC
// - Every return sets global interrupt enable
// - Normal return only when quick status clear
// - Quick return: swap, shadow flags, six cycles
// - Quick interrupt entry swaps PC and pointer
// - Conditional jump loads direct address
// - Indirect jump loads PC from pair
// - Jump first byte: condition then opcode
// - Pair's first register is high byte
`timescale 1ns/1ps
module cpie_exec
  import cpie_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // AXI4-Lite write channels
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read channels
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Program memory
  output logic [15:0] prog_addr_o,
  input wire logic [7:0] prog_data_i,
  // Interrupt and power
  input wire logic irq_i,
  output logic int_ack_o,
  output logic cpu_clk_en_o,
  output logic idle_o
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  cpie_st_t state_reg;
  logic [7:0] rf [0:255];
  logic [15:0] pc_reg, sp_reg, ip_reg;
  logic [7:0] flags_reg, shadow_reg, sym_reg, ctrl_reg;
  logic [7:0] op_reg, b1_reg, b2_reg;
  logic [3:0] cnt_reg, cyc_reg;
  logic [8:0] aw_idx_reg;
  logic [31:0] wd_reg;
  logic [3:0] ws_reg;
  logic aw_got_reg, w_got_reg;

  // ----------------------------------------
  // Decode and execute
  // ----------------------------------------
  logic commit, boundary, cond, wr_fire, run;
  logic [7:0] ta, wh, wl, inc_b;
  logic [15:0] inc_w, pc_next;
  logic [7:0] fl_next;
  logic [3:0] cyc_first;

  assign run = ctrl_reg[CTRL_RUN];
  assign commit = (state_reg == ST_EXEC) && (cnt_reg == cyc_reg - 4'h1)
    && (cnt_reg != 4'h0);
  assign boundary = commit || (state_reg == ST_INTR
    && cnt_reg == CYC_INT_ENTRY - 4'h1);

  // Cycle count from the opcode byte as it arrives
  always_comb
  begin
    cyc_first = CYC_BASIC;
    if (prog_data_i == OP_ADD_ONE_WORD_RR || prog_data_i == OP_ADD_ONE_WORD_IR)
      cyc_first = CYC_WORD;
    else if (prog_data_i[3:0] == NIB_JP_CC || prog_data_i == OP_JP_IRR)
      cyc_first = CYC_JP;
    else if (prog_data_i == OP_SERVICE_RETURN)
      cyc_first = flags_reg[FL_FIS] ? CYC_SERVICE_RETURN_FAST
        : CYC_SERVICE_RETURN_NORM;
  end

  // Condition code in the upper nibble
  always_comb
  begin
    case (op_reg[7:4])
      4'h0: cond = 1'b0;
      4'h1: cond = flags_reg[FL_S] ^ flags_reg[FL_V];
      4'h2: cond = flags_reg[FL_Z] | (flags_reg[FL_S] ^ flags_reg[FL_V]);
      4'h3: cond = flags_reg[FL_C] | flags_reg[FL_Z];
      4'h4: cond = flags_reg[FL_V];
      4'h5: cond = flags_reg[FL_S];
      4'h6: cond = flags_reg[FL_Z];
      4'h7: cond = flags_reg[FL_C];
      4'h8: cond = 1'b1;
      4'h9: cond = ~(flags_reg[FL_S] ^ flags_reg[FL_V]);
      4'ha: cond = ~(flags_reg[FL_Z]
        | (flags_reg[FL_S] ^ flags_reg[FL_V]));
      4'hb: cond = ~(flags_reg[FL_C] | flags_reg[FL_Z]);
      4'hc: cond = ~flags_reg[FL_V];
      4'hd: cond = ~flags_reg[FL_S];
      4'he: cond = ~flags_reg[FL_Z];
      default: cond = ~flags_reg[FL_C];
    endcase
  end

  // Target address and increment results
  always_comb
  begin
    ta = b1_reg;
    if (op_reg[3:0] == NIB_INC_WR)
      ta = {WREG_HI, op_reg[7:4]};
    else if (op_reg == OP_INC_IR || op_reg == OP_ADD_ONE_WORD_IR)
      ta = rf[b1_reg];
  end
  assign wh = {ta[7:1], 1'b0};
  assign wl = {ta[7:1], 1'b1};
  assign inc_b = rf[ta] + 8'h01;
  assign inc_w = {rf[wh], rf[wl]} + 16'h0001;

  // Next PC and flags at commit
  always_comb
  begin
    pc_next = pc_reg + LEN_ONE;
    fl_next = flags_reg;
    if (op_reg[3:0] == NIB_INC_WR)
    begin
      fl_next[FL_Z] = (inc_b == 8'h00);
      fl_next[FL_S] = inc_b[7];
      fl_next[FL_V] = (inc_b == BYTE_MIN);
    end
    else if (op_reg == OP_INC_R || op_reg == OP_INC_IR)
    begin
      pc_next = pc_reg + LEN_TWO;
      fl_next[FL_Z] = (inc_b == 8'h00);
      fl_next[FL_S] = inc_b[7];
      fl_next[FL_V] = (inc_b == BYTE_MIN);
    end
    else if (op_reg == OP_ADD_ONE_WORD_RR || op_reg == OP_ADD_ONE_WORD_IR)
    begin
      pc_next = pc_reg + LEN_TWO;
      fl_next[FL_Z] = (inc_w == 16'h0000);
      fl_next[FL_S] = inc_w[15];
      fl_next[FL_V] = (inc_w == WORD_MIN);
    end
    else if (op_reg[3:0] == NIB_JP_CC)
      pc_next = cond ? {b1_reg, b2_reg}
        : pc_reg + LEN_THREE;
    else if (op_reg == OP_JP_IRR)
      pc_next = {rf[b1_reg], rf[b1_reg + 8'h01]};
    else if (op_reg == OP_SERVICE_RETURN && flags_reg[FL_FIS])
    begin
      pc_next = ip_reg;
      fl_next = shadow_reg;
      fl_next[FL_FIS] = 1'b0;
    end
    else if (op_reg == OP_SERVICE_RETURN)
    begin
      fl_next = rf[sp_reg[7:0]];
      pc_next = {rf[sp_reg[7:0] + 8'h01], rf[sp_reg[7:0] + 8'h02]};
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_reg <= ST_STOP;
      cnt_reg <= 4'h0;
      cyc_reg <= CYC_BASIC;
      op_reg <= 8'h00;
      b1_reg <= 8'h00;
      b2_reg <= 8'h00;
      prog_addr_o <= PC_RST;
      int_ack_o <= 1'b0;
      cpu_clk_en_o <= 1'b1;
      idle_o <= 1'b0;
    end
    else
    begin
      int_ack_o <= 1'b0;
      case (state_reg)
        ST_STOP:
        begin
          prog_addr_o <= pc_reg;
          cnt_reg <= 4'h0;
          if (run)
            state_reg <= ST_EXEC;
        end
        ST_EXEC:
        begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == 4'h0)
          begin
            op_reg <= prog_data_i;
            cyc_reg <= cyc_first;
          end
          if (cnt_reg == 4'h1)
            b1_reg <= prog_data_i;
          if (cnt_reg == 4'h2)
            b2_reg <= prog_data_i;
          if (cnt_reg < 4'h2)
            prog_addr_o <= prog_addr_o + LEN_ONE;
          if (commit)
          begin
            cnt_reg <= 4'h0;
            prog_addr_o <= pc_next;
            if (op_reg == OP_IDLE)
            begin
              state_reg <= ST_IDLE;
              cpu_clk_en_o <= 1'b0;
              idle_o <= 1'b1;
            end
            else if (irq_i && sym_reg[SYM_GIE] && op_reg != OP_SERVICE_RETURN)
              state_reg <= ST_INTR;
            else if (!run)
              state_reg <= ST_STOP;
          end
        end
        ST_IDLE:
        begin
          cnt_reg <= 4'h0;
          if (irq_i)
          begin
            cpu_clk_en_o <= 1'b1;
            idle_o <= 1'b0;
            state_reg <= sym_reg[SYM_GIE] ? ST_INTR
              : ST_EXEC;
          end
        end
        default:
        begin
          cnt_reg <= cnt_reg + 4'h1;
          if (boundary)
          begin
            cnt_reg <= 4'h0;
            int_ack_o <= 1'b1;
            prog_addr_o <= ip_reg;
            state_reg <= ST_EXEC;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Program counter, stack and thread pointers
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pc_reg <= PC_RST;
      sp_reg <= SP_RST;
      ip_reg <= IP_RST;
    end
    else if (state_reg == ST_INTR && boundary)
    begin
      pc_reg <= ip_reg;
      ip_reg <= pc_reg;
    end
    else if (commit)
    begin
      pc_reg <= pc_next;
      if (op_reg == OP_SERVICE_RETURN && flags_reg[FL_FIS])
        ip_reg <= pc_reg + LEN_ONE;
      else if (op_reg == OP_SERVICE_RETURN)
        sp_reg <= sp_reg + LEN_THREE;
    end
    else if (wr_fire && state_reg == ST_STOP)
    begin
      if (aw_idx_reg == IDX_PC)
        pc_reg <= wd_reg[15:0];
      if (aw_idx_reg == IDX_SP)
        sp_reg <= wd_reg[15:0];
      if (aw_idx_reg == IDX_IP)
        ip_reg <= wd_reg[15:0];
    end
  end

  // ----------------------------------------
  // Flags, shadow, mode and control
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      flags_reg <= FLAGS_RST;
      shadow_reg <= FLAGS_RST;
      sym_reg <= SYM_RST;
      ctrl_reg <= 8'h00;
    end
    else
    begin
      if (wr_fire && aw_idx_reg == IDX_CTRL && ws_reg[0])
        ctrl_reg <= wd_reg[7:0];
      if (wr_fire && aw_idx_reg == IDX_SHADOW && ws_reg[0])
        shadow_reg <= wd_reg[7:0];
      if (wr_fire && aw_idx_reg == IDX_SYM && ws_reg[0])
        sym_reg <= wd_reg[7:0];
      if (wr_fire && aw_idx_reg == IDX_FLAGS && ws_reg[0])
        flags_reg <= wd_reg[7:0];
      // Core updates win over a bus write in the same cycle
      if (state_reg == ST_INTR && boundary)
      begin
        shadow_reg <= flags_reg;
        flags_reg[FL_FIS] <= 1'b1;
        sym_reg[SYM_GIE] <= 1'b0;
      end
      else if (commit)
      begin
        flags_reg <= fl_next;
        if (op_reg == OP_SERVICE_RETURN)
          sym_reg[SYM_GIE] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (commit && (op_reg == OP_ADD_ONE_WORD_RR || op_reg == OP_ADD_ONE_WORD_IR))
    begin
      rf[wh] <= inc_w[15:8];
      rf[wl] <= inc_w[7:0];
    end
    else if (commit && (op_reg[3:0] == NIB_INC_WR
      || op_reg == OP_INC_R || op_reg == OP_INC_IR))
      rf[ta] <= inc_b;
    else if (wr_fire && !aw_idx_reg[8] && ws_reg[0]
      && aw_idx_reg != IDX_FLAGS)
      rf[aw_idx_reg[7:0]] <= wd_reg[7:0];
  end

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid_o;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_idx_reg <= 9'h000;
      wd_reg <= 32'h0000_0000;
      ws_reg <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_got_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr_i[10:2];
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_got_reg <= 1'b1;
        wd_reg <= s_axi_wdata_i;
        ws_reg <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_fire)
      begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= (aw_idx_reg > IDX_SHADOW
          || aw_idx_reg == IDX_STAT) ? RESP_SLVERR : RESP_OKAY;
      end
      if (s_axi_bvalid_o && s_axi_bready_i)
      begin
        s_axi_bvalid_o <= 1'b0;
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  logic [8:0] ar_idx;
  logic [31:0] rd_val;
  logic rd_err;

  assign ar_idx = s_axi_araddr_i[10:2];

  // Read mux over the register map
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    if (s_axi_araddr_i[11])
      rd_err = 1'b1;
    else if (ar_idx == IDX_FLAGS)
      rd_val[7:0] = flags_reg;
    else if (!ar_idx[8])
      rd_val[7:0] = rf[ar_idx[7:0]];
    else if (ar_idx == IDX_PC)
      rd_val[15:0] = pc_reg;
    else if (ar_idx == IDX_SP)
      rd_val[15:0] = sp_reg;
    else if (ar_idx == IDX_IP)
      rd_val[15:0] = ip_reg;
    else if (ar_idx == IDX_SYM)
      rd_val[7:0] = sym_reg;
    else if (ar_idx == IDX_CTRL)
      rd_val[7:0] = ctrl_reg;
    else if (ar_idx == IDX_STAT)
      rd_val[7:0] = {5'h00, idle_o, state_reg};
    else if (ar_idx == IDX_SHADOW)
      rd_val[7:0] = shadow_reg;
    else
      rd_err = 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_val;
      s_axi_rresp_o <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_rvalid_o && s_axi_rready_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end
endmodule

// File: core/cpie_pkg.sv
// Constants for the idle, increment, return and jump execution unit.
// Assumes a 40 MHz core clock and an AXI4-Lite register port.
package cpie_pkg;
  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_IDLE = 8'h6f;
  localparam logic [7:0] OP_INC_R = 8'h20;
  localparam logic [7:0] OP_INC_IR = 8'h21;
  localparam logic [7:0] OP_ADD_ONE_WORD_RR = 8'ha0;
  localparam logic [7:0] OP_ADD_ONE_WORD_IR = 8'ha1;
  localparam logic [7:0] OP_SERVICE_RETURN = 8'hbf;
  localparam logic [7:0] OP_JP_IRR = 8'h30;
  localparam logic [3:0] NIB_INC_WR = 4'he;
  localparam logic [3:0] NIB_JP_CC = 4'hd;
  // ----------------------------------------
  // Cycle counts and lengths
  // ----------------------------------------
  localparam logic [3:0] CYC_BASIC = 4'h4;
  localparam logic [3:0] CYC_WORD = 4'h8;
  localparam logic [3:0] CYC_JP = 4'h8;
  localparam logic [3:0] CYC_SERVICE_RETURN_FAST = 4'h6;
  localparam logic [3:0] CYC_SERVICE_RETURN_NORM = 4'ha;
  localparam logic [3:0] CYC_INT_ENTRY = 4'h4;
  localparam logic [15:0] LEN_ONE = 16'h0001;
  localparam logic [15:0] LEN_TWO = 16'h0002;
  localparam logic [15:0] LEN_THREE = 16'h0003;
  // ----------------------------------------
  // Flag bit positions and working registers
  // ----------------------------------------
  localparam int FL_C = 7;
  localparam int FL_Z = 6;
  localparam int FL_S = 5;
  localparam int FL_V = 4;
  localparam int FL_FIS = 1;
  localparam int SYM_GIE = 0;
  localparam int CTRL_RUN = 0;
  localparam logic [3:0] WREG_HI = 4'hc;
  localparam logic [7:0] BYTE_MIN = 8'h80;
  localparam logic [15:0] WORD_MIN = 16'h8000;
  // ----------------------------------------
  // Register indices, byte address = 4 * index
  // ----------------------------------------
  localparam logic [8:0] IDX_FLAGS = 9'h0d5;
  localparam logic [8:0] IDX_PC = 9'h100;
  localparam logic [8:0] IDX_SP = 9'h101;
  localparam logic [8:0] IDX_IP = 9'h102;
  localparam logic [8:0] IDX_SYM = 9'h103;
  localparam logic [8:0] IDX_CTRL = 9'h104;
  localparam logic [8:0] IDX_STAT = 9'h105;
  localparam logic [8:0] IDX_SHADOW = 9'h106;
  // ----------------------------------------
  // Reset values and bus answers
  // ----------------------------------------
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [15:0] IP_RST = 16'h0000;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] SYM_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {ST_STOP, ST_EXEC, ST_IDLE, ST_INTR} cpie_st_t;
endpackage

// File: test/cpie_exec_monitor.sv
// Port checker for the idle, increment, return and jump unit.
// Assumes it is bound to cpie_exec and sees only that module's ports.
`timescale 1ns/1ps
module cpie_exec_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Register bus
  input wire logic s_axi_awready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Interrupt and power
  input wire logic irq_i,
  input wire logic int_ack_o,
  input wire logic cpu_clk_en_o,
  input wire logic idle_o
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  a_idle_clk_off: assert property (idle_o == !cpu_clk_en_o)
    else $error("clock enable and idle disagree");
  a_irq_wakes: assert property (idle_o && irq_i |=> !idle_o)
    else $error("request did not end idle");
  a_reset_wakes: assert property ($fell(srst_i) |-> !idle_o && cpu_clk_en_o)
    else $error("idle seen right after reset");
  a_ack_pulse: assert property (int_ack_o |=> !int_ack_o)
    else $error("acknowledge longer than one cycle");
  a_ack_clock_on: assert property (int_ack_o |-> !idle_o && cpu_clk_en_o)
    else $error("acknowledge while clock stopped");
  a_bresp_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i
    |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  a_rdata_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped early");
  a_read_latency: assert property (s_axi_arvalid_i && s_axi_arready_o
    |=> s_axi_rvalid_o ##0 !s_axi_arready_o)
    else $error("read answer not after one cycle");
  a_aw_blocked: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
    else $error("address taken while response pending");

  // Main scenarios reached
  c_idle: cover property ($rose(idle_o));
  c_ack: cover property (int_ack_o);
  c_wr_err: cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'b10);
  c_rd_err: cover property (s_axi_rvalid_o && s_axi_rresp_o == 2'b10);
endmodule

// File: test/test_cpie_exec.sv
// Self-checking bench for the execution unit.
// Assumes the bench plays bus master, program memory and interrupt source.
`timescale 1ns/1ps
module test_cpie_exec
  import cpie_pkg::*;
();
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [11:0] s_axi_awaddr_i = 12'h000;
  logic s_axi_awvalid_i = 1'b0;
  logic [31:0] s_axi_wdata_i = 32'h0000_0000;
  logic [3:0] s_axi_wstrb_i = 4'hf;
  logic s_axi_wvalid_i = 1'b0;
  logic s_axi_bready_i = 1'b0;
  logic [11:0] s_axi_araddr_i = 12'h000;
  logic s_axi_arvalid_i = 1'b0;
  logic s_axi_rready_i = 1'b0;
  logic irq_i = 1'b0;
  logic [7:0] prog_data_i;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o, int_ack_o, cpu_clk_en_o, idle_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  logic [15:0] prog_addr_o;
  logic [7:0] rom [0:255];
  logic [7:0] prg [13] = '{8'h1e, 8'h20, 8'h10, 8'ha0, 8'h12, 8'h21, 8'h16,
    8'hfd, 8'h00, 8'h50, 8'h7d, 8'h00, 8'h40};
  logic [7:0] v;
  logic [33:0] exp_r [$];
  logic [1:0] exp_b [$];
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  // Clock and program memory
  always #12.5 clk_i = ~clk_i;
  assign prog_data_i = rom[prog_addr_o[7:0]];

  cpie_exec DUT (.clk_i, .srst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .prog_addr_o,
    .prog_data_i, .irq_i, .int_ack_o, .cpu_clk_en_o, .idle_o);

  // ----------------------------------------
  // Comparison and report
  // ----------------------------------------
  task chk_val(input string nm, input logic [33:0] e, input logic [33:0] s);
    total_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task chk_resp(input logic [1:0] e, input logic [1:0] s);
    chk_val("bresp", {32'h0, e}, {32'h0, s});
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Takes the oldest note off a queue whenever a bus answer appears
  always @(posedge clk_i)
  begin
    if (s_axi_rvalid_o && s_axi_rready_i)
      chk_val("rdata", exp_r.pop_front(), {s_axi_rresp_o, s_axi_rdata_o});
    if (s_axi_bvalid_o && s_axi_bready_i)
      chk_resp(exp_b.pop_front(), s_axi_bresp_o);
  end

  // Cuts a hang short
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Bus master tasks and idle wait
  // ----------------------------------------
  task wr(input logic [8:0] idx, input logic [31:0] d,
    input logic [1:0] r = RESP_OKAY);
    logic aw;
    logic w;
    exp_b.push_back(r);
    s_axi_awaddr_i <= {1'b0, idx, 2'b00};
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    while (!(aw && w))
    begin
      @(posedge clk_i);
      if (!aw && s_axi_awready_o)
      begin
        aw = 1'b1;
        s_axi_awvalid_i <= 1'b0;
      end
      if (!w && s_axi_wready_o)
      begin
        w = 1'b1;
        s_axi_wvalid_i <= 1'b0;
      end
    end
    while (!s_axi_bvalid_o) @(posedge clk_i);
    s_axi_bready_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task rd(input logic [8:0] idx, input logic [31:0] d,
    input logic [1:0] r = RESP_OKAY);
    exp_r.push_back({r, d});
    s_axi_araddr_i <= {1'b0, idx, 2'b00};
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    @(posedge clk_i);
    while (!s_axi_arready_o) @(posedge clk_i);
    s_axi_arvalid_i <= 1'b0;
    while (!s_axi_rvalid_o) @(posedge clk_i);
    s_axi_rready_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task wait_idle;
    while (!idle_o) @(posedge clk_i);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    v = 8'($urandom(22));
    for (int i = 0; i < 256; i++) rom[i] = 8'hff;
    // Byte increments of all three forms, word pair form with carry into the high byte, jumps NC and C
    for (int i = 0; i < 13; i++) rom[i] = prg[i];
    rom[8'h40] = OP_IDLE;
    rom[8'h44] = OP_JP_IRR;
    rom[8'h45] = 8'h14;
    rom[8'h60] = OP_IDLE;
    rom[8'h80] = OP_SERVICE_RETURN;
    rom[8'h90] = OP_SERVICE_RETURN;
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    // Reset values and refused places
    rd(IDX_PC, 32'h0);
    rd(IDX_FLAGS, 32'h0);
    rd(9'h107, 32'h0, RESP_SLVERR);
    wr(IDX_STAT, 32'h0, RESP_SLVERR);
    $display("test reset and bus done");
    // Operands, flags with carry set, handler address
    v = 8'($urandom);
    wr(9'h010, {24'h0, v});
    wr(9'h0c1, 32'hff);
    wr(9'h012, 32'h00);
    wr(9'h013, 32'hff);
    wr(9'h014, 32'h00);
    wr(9'h015, 32'h60);
    wr(9'h016, 32'h17);
    wr(9'h017, 32'h7f);
    wr(IDX_FLAGS, 32'h80);
    wr(IDX_SYM, 32'h1);
    wr(IDX_IP, 32'h80);
    wr(IDX_CTRL, 32'h1);
    wait_idle();
    chk_val("clk_en", 34'h0, cpu_clk_en_o);
    irq_i <= 1'b1;
    while (!int_ack_o) @(posedge clk_i);
    chk_val("idle", 34'h0, idle_o);
    chk_val("prog_addr", 34'h80, prog_addr_o);
    irq_i <= 1'b0;
    @(posedge clk_i);
    wait_idle();
    rd(9'h0c1, 32'h00);
    rd(9'h010, {24'h0, v + 8'h01});
    rd(9'h017, 32'h80);
    rd(9'h012, 32'h01);
    rd(9'h013, 32'h00);
    rd(IDX_FLAGS, 32'hb0);
    rd(IDX_SYM, 32'h1);
    rd(IDX_IP, 32'h81);
    rd(IDX_PC, 32'h61);
    $display("test quick service done");
    // Reset ends idle, then a stacked return
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    chk_val("idle", 34'h0, idle_o);
    wr(9'h020, 32'h55);
    wr(9'h021, 32'h00);
    wr(9'h022, 32'h60);
    wr(IDX_FLAGS, 32'h00);
    wr(IDX_SP, 32'h20);
    wr(IDX_PC, 32'h90);
    wr(IDX_CTRL, 32'h1);
    wait_idle();
    rd(IDX_FLAGS, 32'h55);
    rd(IDX_SP, 32'h23);
    rd(IDX_SYM, 32'h1);
    rd(IDX_PC, 32'h61);
    $display("test stacked return done");
    end_of_test();
  end
endmodule

bind cpie_exec cpie_exec_monitor mon (.clk_i, .srst_i, .s_axi_awready_o,
  .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i,
  .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
  .s_axi_rready_i, .irq_i, .int_ack_o, .cpu_clk_en_o, .idle_o);
